// [acd_capture.v]
// Converter control with APB registers, limit check and transfer hand-off
`timescale 1ns/1ps
`include "acd_regs.vh"

module acd_capture (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output wire pslverr_o,
  output reg [31:0] prdata_o,
  // Analog front end: sampled code from the selected input
  input wire [9:0] analog_input_zero_i,
  output reg sample_o,
  // Events to the CPU
  output wire conv_end_irq_o,
  output reg conversion_end_signal_o
);

  // --------------------------------------------------------------------------
  // State and registers
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 1'b0; // Stopped or standby
  localparam ST_CONV = 1'b1; // Converting
  localparam [31:0] CONV_CYC_W = `ACD_CONV_CYC; // Full-width count
  localparam [12:0] CONV_CYC = CONV_CYC_W[12:0]; // Count fits the 13-bit counter

  reg state; // Conversion sequencer state
  reg [7:0] converter_mode_zero; // Run and comparator enable
  reg [7:0] interrupt_mask_high; // Bit 0 is the end mask
  reg conv_end_irq_flag; // Pending end request
  reg [7:0] compare_upper_limit; // Inclusive upper bound
  reg [7:0] compare_lower_limit; // Inclusive lower bound
  reg [15:0] conversion_result; // Left-aligned result
  reg [12:0] conv_cnt; // Cycles left in this conversion
  reg [2:0] pad_s1; // Unused spare stage, tied to zero
  reg [9:0] pad_s2; // Input sync stage two
  reg [9:0] pad_s3; // Input sync stage three
  reg [9:0] pad_stable; // Accepted input code
  reg [9:0] pad_a; // First flop of the sync
  reg [31:0] next_rdata; // Read mux output
  reg next_in_range; // Limit check outcome

  wire wr_acc; // APB write access phase
  wire rd_acc; // APB read access phase
  wire run; // Run bit
  wire conv_done; // Last cycle of a conversion
  wire xfer_done; // Eighth transfer finished
  wire xfer_en; // Transfer activation enabled
  wire [3:0] xfer_count; // Transfers left
  wire [2:0] xfer_ptr; // Next ring element
  wire [19:0] xfer_src; // Source address
  wire [19:0] xfer_dst; // Destination address
  wire [15:0] ring_data; // Ring read data
  wire flag_clr; // Software clears request flag

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  // Match on a register offset, ignoring the byte lanes
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr[11:2] == off[11:2]);
    end
  endfunction

  // Ring window covers eight words from its base
  function ring_hit;
    input [11:0] addr;
    begin
      ring_hit = (addr[11:5] == `ACD_OFF_RING0 >> 5);
    end
  endfunction

  // --------------------------------------------------------------------------
  // APB handshake: zero wait states, no error answer
  // --------------------------------------------------------------------------
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  assign run = converter_mode_zero[`ACD_BIT_RUN];
  assign conv_done = (state == ST_CONV) && (conv_cnt == 13'h0001) && run;
  assign flag_clr = wr_acc && hit(paddr_i, `ACD_OFF_FLAG) && !pwdata_i[`ACD_BIT_FLAG];

  // Servicing only while the mask bit is clear
  assign conv_end_irq_o = conv_end_irq_flag && !interrupt_mask_high[`ACD_BIT_MASK];

  // --------------------------------------------------------------------------
  // Input synchroniser: the analog code comes from another domain
  // --------------------------------------------------------------------------
  // Stage one only feeds stage two; a change counts once two and three agree
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_a <= 10'h000;
      pad_s2 <= 10'h000;
      pad_s3 <= 10'h000;
      pad_stable <= 10'h000;
    end else begin
      pad_a <= analog_input_zero_i;
      pad_s2 <= pad_a;
      pad_s3 <= pad_s2;
      if (pad_s2 == pad_s3) begin
        pad_stable <= pad_s3;
      end
    end
  end

  // Unused spare stage kept tied for clarity of reset
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_s1 <= 3'h0;
    end else begin
      pad_s1 <= 3'h0;
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      converter_mode_zero <= `ACD_RST_MODE0;
      interrupt_mask_high <= `ACD_RST_MASK;
      compare_upper_limit <= `ACD_RST_UPPER;
      compare_lower_limit <= `ACD_RST_LOWER;
    end else if (wr_acc) begin
      if (hit(paddr_i, `ACD_OFF_MODE0)) begin
        converter_mode_zero <= pwdata_i[7:0]; // Run bit written here
      end
      if (hit(paddr_i, `ACD_OFF_MASK)) begin
        interrupt_mask_high <= pwdata_i[7:0];
      end
      if (hit(paddr_i, `ACD_OFF_UPPER)) begin
        compare_upper_limit <= pwdata_i[7:0];
      end
      if (hit(paddr_i, `ACD_OFF_LOWER)) begin
        compare_lower_limit <= pwdata_i[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  // Clearing the run bit aborts at once; a set run bit restarts forever
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      conv_cnt <= 13'h0000;
      sample_o <= 1'b0;
    end else begin
      sample_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (run) begin
            state <= ST_CONV;
            conv_cnt <= CONV_CYC;
            sample_o <= 1'b1;
          end
        end
        ST_CONV: begin
          if (!run) begin
            state <= ST_IDLE; // Stop on run cleared
            conv_cnt <= 13'h0000;
          end else if (conv_cnt == 13'h0001) begin
            conv_cnt <= CONV_CYC; // Same input again
            sample_o <= 1'b1;
          end else begin
            conv_cnt <= conv_cnt - 13'h0001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Limit check on the upper eight result bits
  // --------------------------------------------------------------------------
  always @* begin
    next_in_range = (pad_stable[9:2] >= compare_lower_limit) &&
                    (pad_stable[9:2] <= compare_upper_limit);
  end

  // --------------------------------------------------------------------------
  // Result capture and end signal
  // --------------------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conversion_result <= 16'h0000;
      conversion_end_signal_o <= 1'b0;
    end else begin
      conversion_end_signal_o <= 1'b0;
      if (conv_done) begin
        // Result sits in the top ten bits, software shifts
        conversion_result <= {pad_stable, 6'h00};
        conversion_end_signal_o <= next_in_range;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Request flag: set by the eighth transfer, or by each end while idle
  // --------------------------------------------------------------------------
  // Set wins over a clear in the same cycle so no event is lost
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_end_irq_flag <= 1'b0;
    end else if (xfer_done) begin
      conv_end_irq_flag <= 1'b1;
    end else if (conversion_end_signal_o && !xfer_en) begin
      conv_end_irq_flag <= 1'b1; // No transfer armed
    end else if (flag_clr) begin
      conv_end_irq_flag <= 1'b0; // Software clear
    end
  end

  // --------------------------------------------------------------------------
  // Transfer engine
  // --------------------------------------------------------------------------
  acd_xfer u_xfer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .xfer_en_i(pwdata_i[`ACD_BIT_XEN]),
    .xfer_en_set_i(wr_acc && hit(paddr_i, `ACD_OFF_XFER)),
    .trig_i(conversion_end_signal_o),
    .src_data_i(conversion_result),
    .rd_idx_i(paddr_i[4:2]),
    .rd_data_o(ring_data),
    .xfer_en_o(xfer_en),
    .count_o(xfer_count),
    .ptr_o(xfer_ptr),
    .src_addr_o(xfer_src),
    .dst_addr_o(xfer_dst),
    .done_o(xfer_done)
  );

  // --------------------------------------------------------------------------
  // Read mux; ring reads answer with data fetched in the setup cycle
  // --------------------------------------------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit(paddr_i, `ACD_OFF_MODE0)) begin
      // Run bit reads back the sequencer activity
      next_rdata = {24'h000000, (state == ST_CONV), converter_mode_zero[6:0]};
    end else if (hit(paddr_i, `ACD_OFF_MASK)) begin
      next_rdata = {24'h000000, interrupt_mask_high};
    end else if (hit(paddr_i, `ACD_OFF_FLAG)) begin
      next_rdata = {31'h00000000, conv_end_irq_flag};
    end else if (hit(paddr_i, `ACD_OFF_UPPER)) begin
      next_rdata = {24'h000000, compare_upper_limit};
    end else if (hit(paddr_i, `ACD_OFF_LOWER)) begin
      next_rdata = {24'h000000, compare_lower_limit};
    end else if (hit(paddr_i, `ACD_OFF_XFER)) begin
      next_rdata = {xfer_dst[11:0], xfer_src[7:0], 1'b0, xfer_ptr, xfer_count, 3'h0, xfer_en};
    end else if (hit(paddr_i, `ACD_OFF_RESULT)) begin
      next_rdata = {16'h0000, conversion_result};
    end else if (ring_hit(paddr_i)) begin
      next_rdata = {16'h0000, ring_data};
    end
  end

  // Registered read data, loaded in the setup cycle
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_o <= next_rdata;
    end
  end

endmodule // acd_capture

// [acd_capture_chk.sv]
// Port checker for the capture block, bound to every instance
`timescale 1ns/1ps
`include "acd_regs.vh"
module acd_capture_chk (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // APB slave side
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire [31:0] prdata_o,
  // Converter and events
  input wire [9:0] analog_input_zero_i,
  input wire sample_o,
  input wire conv_end_irq_o,
  input wire conversion_end_signal_o
);
  // ----
  // Shadow of what software wrote
  // ----
  wire wr = psel_i && penable_i && pwrite_i; // Write lands this edge
  reg run_q; // Run bit copy
  reg [1:0] run_h; // Run bit history
  reg mask_q; // Mask bit copy
  reg mask_w; // Mask written last edge
  reg [3:0] end_h; // Recent end pulses, flag set lags them
  // Copies follow the access edge, like the registers
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      run_h <= 2'b00;
      mask_q <= 1'b1;
      mask_w <= 1'b0;
      end_h <= 4'h0;
    end else begin
      if (wr && paddr_i == `ACD_OFF_MODE0) run_q <= pwdata_i[7];
      if (wr && paddr_i == `ACD_OFF_MASK) mask_q <= pwdata_i[0];
      mask_w <= wr && paddr_i == `ACD_OFF_MASK;
      run_h <= {run_h[0], run_q};
      end_h <= {end_h[2:0], conversion_end_signal_o};
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_apb_tied: assert property (pready_o && !pslverr_o)
    else $error("apb answer not tied");
  a_rdata_hold: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o))
    else $error("read data moved outside setup");
  a_end_pulse: assert property (conversion_end_signal_o |=> !conversion_end_signal_o [*8])
    else $error("end pulse too long or too close");
  a_smp_pulse: assert property (sample_o |=> !sample_o)
    else $error("start pulse too long");
  a_run_start: assert property (wr && paddr_i == `ACD_OFF_MODE0 && pwdata_i[7] && !run_q
    |-> ##[1:2] sample_o)
    else $error("run write did not start");
  a_stop_quiet: assert property (!run_q && run_h == 2'b00
    |-> !conversion_end_signal_o && !sample_o)
    else $error("activity while stopped");
  a_irq_masked: assert property (mask_q |-> !conv_end_irq_o)
    else $error("masked request passed");
  a_irq_cause: assert property ($rose(conv_end_irq_o) |-> end_h != 4'h0 || mask_w)
    else $error("request rose without cause");
  a_flag_clear: assert property (wr && paddr_i == `ACD_OFF_FLAG && !pwdata_i[0]
    && end_h == 4'h0 && !conversion_end_signal_o |=> !conv_end_irq_o)
    else $error("flag clear had no effect");
endmodule // acd_capture_chk

bind acd_capture acd_capture_chk chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
  .analog_input_zero_i(analog_input_zero_i), .sample_o(sample_o),
  .conv_end_irq_o(conv_end_irq_o), .conversion_end_signal_o(conversion_end_signal_o));

// [acd_capture_tb_top.sv]
// Self-checking bench for the capture block
`timescale 1ns/1ps
`include "acd_regs.vh"
module acd_capture_tb_top;
  // ----
  // Signals
  // ----
  localparam [31:0] XF_IDLE = 32'h5001e080; // Ring base, source, count 8, idle
  reg core_clk_i; // Core clock
  reg rst_i; // Reset
  reg psel_i; // APB select
  reg penable_i; // APB enable
  reg pwrite_i; // APB direction
  reg [11:0] paddr_i; // APB address
  reg [31:0] pwdata_i; // APB write data
  wire pready_o; // APB ready
  wire pslverr_o; // APB error
  wire [31:0] prdata_o; // APB read data
  wire [9:0] code; // Front-end code
  wire sample_o; // Conversion start
  wire irq; // Request to CPU
  wire end_s; // End pulse
  integer n_fail; // Mismatches
  integer num_checks; // Comparisons
  integer ne; // End pulses seen
  integer ns; // Starts seen
  reg [31:0] q; // Last read word
  reg [15:0] ring_x [0:7]; // Expected ring
  acd_capture dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
    .analog_input_zero_i(code), .sample_o(sample_o), .conv_end_irq_o(irq),
    .conversion_end_signal_o(end_s));
  acd_front_model front_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .sample_i(sample_o),
    .code_o(code));
  // Free-running clock
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // ----
  // Shared tasks
  // ----
  task close_out;
    begin
      if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // One APB transfer; an idle edge comes first, so calls never collide
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
        @(posedge core_clk_i);
        k = k + 1;
      end while (pready_o !== 1'b1 && k < 20);
      if (k == 20) chk("pready", 0, 1);
      q = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task rdc(input string nm, input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, q, e);
    end
  endtask
  task watch(input integer n);
    integer i;
    begin
      ne = 0;
      ns = 0;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge core_clk_i);
        if (end_s === 1'b1) ne = ne + 1;
        if (sample_o === 1'b1) ns = ns + 1;
      end
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    begin
      rdc("mode0", `ACD_OFF_MODE0, 32'h0);
      rdc("mask", `ACD_OFF_MASK, 32'hff);
      rdc("flag", `ACD_OFF_FLAG, 32'h0);
      rdc("upper", `ACD_OFF_UPPER, 32'hff);
      rdc("lower", `ACD_OFF_LOWER, 32'h0);
      rdc("xfer", `ACD_OFF_XFER, XF_IDLE);
      rdc("hole", 12'h0fc, 32'h0);
    end
  endtask
  // Empty limit window: conversions run but never signal
  task t_limits;
    begin
      apb(1'b1, `ACD_OFF_LOWER, 32'h80);
      apb(1'b1, `ACD_OFF_UPPER, 32'h7f);
      apb(1'b1, `ACD_OFF_MODE0, 32'h81);
      watch(400);
      chk("no_end", ne, 0);
      chk("restarts", ns >= 3, 1);
      apb(1'b1, `ACD_OFF_MODE0, 32'h01);
      apb(1'b1, `ACD_OFF_UPPER, 32'hff);
      apb(1'b1, `ACD_OFF_LOWER, 32'h00);
    end
  endtask
  // Handler side: clear flag first, then unmask and re-enable transfers
  task t_arm;
    begin
      apb(1'b1, `ACD_OFF_FLAG, 32'h0);
      rdc("flag_clr", `ACD_OFF_FLAG, 32'h0);
      apb(1'b1, `ACD_OFF_MASK, 32'hfe);
      apb(1'b1, `ACD_OFF_XFER, 32'h1);
      rdc("xfer_on", `ACD_OFF_XFER, XF_IDLE | 32'h1);
      apb(1'b1, `ACD_OFF_MODE0, 32'h81);
      rdc("running", `ACD_OFF_MODE0, 32'h81);
    end
  endtask
  task t_group;
    integer i;
    integer k;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        k = 0;
        do begin
          @(posedge core_clk_i);
          k = k + 1;
        end while (end_s !== 1'b1 && k < 200);
        ring_x[i] = {code, 6'h00};
        chk("end_seen", k < 200, 1);
        chk("irq_early", irq, 0);
      end
      repeat (4) @(posedge core_clk_i);
      chk("irq_done", irq, 1);
      rdc("flag_set", `ACD_OFF_FLAG, 32'h1);
      rdc("result", `ACD_OFF_RESULT, {16'h0, ring_x[7]});
      rdc("xfer_end", `ACD_OFF_XFER, XF_IDLE);
      for (i = 0; i < 8; i = i + 1) begin
        rdc("ring", `ACD_OFF_RING0 + {i[9:0], 2'b00}, {16'h0, ring_x[i]});
      end
    end
  endtask
  task t_stop;
    begin
      apb(1'b1, `ACD_OFF_MASK, 32'hff);
      @(negedge core_clk_i);
      chk("irq_mask", irq, 0);
      apb(1'b1, `ACD_OFF_MODE0, 32'h01);
      rdc("stopped", `ACD_OFF_MODE0, 32'h01);
      watch(300);
      chk("quiet_end", ne, 0);
      chk("quiet_smp", ns, 0);
    end
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    n_fail = 0;
    num_checks = 0;
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_limits;
    t_arm;
    t_group;
    t_stop;
    t_arm;
    t_group;
    t_stop;
    close_out;
  end
  // Hang guard, far beyond the expected few thousand cycles
  initial begin
    #1200000;
    n_fail = n_fail + 1;
    close_out;
  end
endmodule // acd_capture_tb_top

// [acd_front_model.sv]
// Analog front-end model feeding one selected input
`timescale 1ns/1ps
module acd_front_model (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Converter side
  input wire sample_i,
  output reg [9:0] code_o
);
  reg [6:0] age; // Cycles since last start
  // Code moves mid-conversion, so it is settled well before completion
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_o <= 10'h155;
      age <= 7'h7f;
    end else begin
      if (sample_i) age <= 7'h00;
      else if (age != 7'h7f) age <= age + 7'h01;
      if (age == 7'h3c) code_o <= code_o + 10'h0b7;
    end
  end
endmodule // acd_front_model

// [acd_regs.vh]
// Register map, field positions, reset values and timing counts of the capture block
`ifndef ACD_REGS_VH
`define ACD_REGS_VH

// --------------------------------------------------------------------------
// Register byte offsets on the APB
// --------------------------------------------------------------------------
`define ACD_OFF_MODE0    12'h000
`define ACD_OFF_MASK     12'h004
`define ACD_OFF_FLAG     12'h008
`define ACD_OFF_UPPER    12'h00c
`define ACD_OFF_LOWER    12'h010
`define ACD_OFF_XFER     12'h014
`define ACD_OFF_RESULT   12'h018
`define ACD_OFF_RING0    12'h020

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define ACD_BIT_RUN      7
`define ACD_BIT_CMP_EN   0
`define ACD_BIT_MASK     0
`define ACD_BIT_FLAG     0
`define ACD_BIT_XEN      0
`define ACD_RES_LSB      6

// --------------------------------------------------------------------------
// Reset values and fixed settings
// --------------------------------------------------------------------------
`define ACD_RST_MODE0    8'h00
`define ACD_RST_MASK     8'hff
`define ACD_RST_UPPER    8'hff
`define ACD_RST_LOWER    8'h00
`define ACD_SRC_ADDR     20'hfff1e
`define ACD_DST_BASE     20'hff500
`define ACD_RING_LEN     4'h8
`define ACD_BLOCK_BYTES  20'h00002

// --------------------------------------------------------------------------
// Timing: one conversion, in ns, and the derived cycle count at 40 ns
// --------------------------------------------------------------------------
`define ACD_CONV_NS      4750
`define ACD_CLK_NS       40
`define ACD_CONV_CYC     ((`ACD_CONV_NS + `ACD_CLK_NS - 1) / `ACD_CLK_NS)

`endif

// [acd_xfer.v]
// Repeat-mode transfer engine moving results into an eight-word ring
`timescale 1ns/1ps
`include "acd_regs.vh"

module acd_xfer (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Activation control
  input wire xfer_en_i,
  input wire xfer_en_set_i,
  input wire trig_i,
  input wire [15:0] src_data_i,
  // Ring read port
  input wire [2:0] rd_idx_i,
  output reg [15:0] rd_data_o,
  // Status
  output reg xfer_en_o,
  output reg [3:0] count_o,
  output reg [2:0] ptr_o,
  output reg [19:0] src_addr_o,
  output reg [19:0] dst_addr_o,
  output reg done_o
);

  // --------------------------------------------------------------------------
  // Ring storage
  // --------------------------------------------------------------------------
  reg [15:0] ring [0:7]; // Destination repeat area
  wire last_xfer; // This transfer empties the count

  assign last_xfer = (count_o == 4'h1);

  // Ring write, kept without reset since it is plain RAM
  always @(posedge core_clk_i) begin
    if (trig_i && xfer_en_o) begin
      ring[ptr_o] <= src_data_i;
    end
  end

  // Plain read port, so the bus setup edge sees the element it addresses
  always @* begin
    rd_data_o = ring[rd_idx_i];
  end

  // --------------------------------------------------------------------------
  // Count, pointer and activation enable
  // --------------------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_en_o <= 1'b0;
      count_o <= `ACD_RING_LEN;
      ptr_o <= 3'h0;
      src_addr_o <= `ACD_SRC_ADDR;
      dst_addr_o <= `ACD_DST_BASE;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      src_addr_o <= `ACD_SRC_ADDR; // Source never advances
      if (trig_i && xfer_en_o) begin
        ptr_o <= ptr_o + 3'h1; // Wraps from 7 to 0
        if (last_xfer) begin
          // Count spent: stop activation and hand end to CPU
          xfer_en_o <= 1'b0;
          done_o <= 1'b1;
          count_o <= `ACD_RING_LEN;
          dst_addr_o <= `ACD_DST_BASE;
        end else begin
          count_o <= count_o - 4'h1;
          dst_addr_o <= dst_addr_o + `ACD_BLOCK_BYTES;
        end
      end else if (xfer_en_set_i) begin
        xfer_en_o <= xfer_en_i; // Handler re-arms
      end
    end
  end

endmodule // acd_xfer
